/* File: rtl/misstep_regs.svh */
// Register offsets, field positions, reset values and timing counts of the misstep monitor.
`ifndef MISSTEP_REGS_SVH
`define MISSTEP_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_BAND 12'h004
`define OFS_ENC_RES 12'h008
`define OFS_MOTOR_RES 12'h00C
`define OFS_PRESET_POS 12'h010
`define OFS_ENC_PRESET 12'h014
`define OFS_CMD_POS 12'h018
`define OFS_ENC_CNT 12'h01C
`define OFS_FB_POS 12'h020
`define OFS_WRAP_CTRL 12'h024
`define OFS_WRAP_VALUE 12'h028
`define OFS_STATUS 12'h02C
`define OFS_GPO 12'h030

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_ACTION_LSB 1
`define CTRL_OUTSEL_LSB 4
`define CTRL_ENC_PRESET_BIT 8
`define CTRL_CNT_CLEAR_BIT 9
`define CTRL_ALM_RESET_BIT 10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_BAND 12'h048
`define RST_ENC_RES 14'h01F4
`define RST_MOTOR_RES 18'h0_01F4
`define RST_OUTSEL 3'h7
`define RST_WRAP_VALUE 32'h0000_03E8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PCLK_HZ 50000000
`define SETTLE_MS 500
`define EDGES_PER_LINE 4
`define DEG_TENTHS_PER_REV 3600

`endif

/* File: rtl/misstep_pkg.sv */
// Types shared by the misstep monitor modules.
package misstep_pkg;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_WARN = 2'b01,
    ACT_ALARM = 2'b10
  } action_t;

  typedef enum logic [1:0] {
    ALM_IDLE = 2'b00,
    ALM_ACTIVE = 2'b01,
    ALM_RESET_SEEN = 2'b10
  } alarm_state_t;

endpackage : misstep_pkg

/* File: rtl/quad_decoder.sv */
// Quadrature decoder: synchronises channel A/B and emits count pulses.
`timescale 1ns/1ps
module quad_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enc_a,
  input wire logic enc_b,
  output logic cnt_up,
  output logic cnt_dn
);

  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 2'h0;
      sync_r <= 2'h0;
      prev_r <= 2'h0;
    end else begin
      meta_r <= {enc_a, enc_b};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Every legal edge of either channel counts once, four counts per line.
  // A double change means an edge was lost, so the direction is unknown
  // and the step is dropped rather than guessed.
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_up <= 1'b0;
      cnt_dn <= 1'b0;
    end else begin
      cnt_up <= 1'b0;
      cnt_dn <= 1'b0;
      unique case ({prev_r, sync_r})
        4'b0010, 4'b1011, 4'b1101, 4'b0100: cnt_up <= 1'b1;
        4'b0001, 4'b0111, 4'b1110, 4'b1000: cnt_dn <= 1'b1;
        default: ;
      endcase
    end
  end

endmodule : quad_decoder

/* File: rtl/deviation_calc.sv */
// Deviation between command and encoder position, scaled to a common angle.
`timescale 1ns/1ps
`include "misstep_regs.svh"
module deviation_calc (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic signed [31:0] cmd_pos,
  input wire logic signed [31:0] enc_cnt,
  input wire logic [17:0] motor_res,
  input wire logic [13:0] enc_res,
  input wire logic [11:0] band,
  output logic over_band
);

  function automatic logic [65:0] abs66(input logic signed [65:0] v);
    abs66 = v[65] ? 66'(-v) : 66'(v);
  endfunction : abs66

  // Both sides are cross-multiplied so that no divider is needed.
  logic signed [65:0] cmd_term_r;
  logic signed [65:0] enc_term_r;
  logic [65:0] lhs;
  logic [65:0] rhs_r;
  logic [15:0] enc_edges;

  assign enc_edges = 16'(enc_res) * 16'(`EDGES_PER_LINE);
  assign lhs = 66'(abs66(cmd_term_r - enc_term_r) * 66'(`DEG_TENTHS_PER_REV));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_term_r <= '0;
      enc_term_r <= '0;
      rhs_r <= '0;
      over_band <= 1'b0;
    end else begin
      cmd_term_r <= 66'(cmd_pos) * 66'($signed({1'b0, enc_edges}));
      enc_term_r <= 66'(enc_cnt) * 66'($signed({1'b0, motor_res}));
      rhs_r <= 66'(band) * 66'(motor_res) * 66'(enc_edges);
      over_band <= (lhs >= rhs_r);
    end
  end

endmodule : deviation_calc

/* File: rtl/encoder_misstep_monitor.sv */
// Position tracking and misstep detection with an APB register slave.
`timescale 1ns/1ps
`include "misstep_regs.svh"
module encoder_misstep_monitor
  import misstep_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = `SETTLE_MS * (`PCLK_HZ / 1000)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step_pulse,
  input wire logic step_dir,
  input wire logic motor_excited,
  input wire logic home_done,
  input wire logic mech_home_busy,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic preset_pin,
  input wire logic alarm_reset_input,
  output logic deviation_error,
  output logic deviation_warning,
  output logic deviation_alarm,
  output logic general_output_first,
  output logic general_output_second,
  output logic general_output_third,
  output logic general_output_fourth,
  output logic general_output_fifth,
  output logic general_output_last
);

  // ----------------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------------
  logic enable_r;
  action_t action_r;
  logic [2:0] out_sel_r;
  logic [11:0] band_r;
  logic [13:0] enc_res_r;
  logic [17:0] motor_res_r;
  logic signed [23:0] preset_pos_r;
  logic signed [23:0] enc_preset_r;
  logic wrap_en_r;
  logic [31:0] wrap_value_r;
  logic [5:0] gpo_r;
  logic enc_preset_cmd_r;
  logic cnt_clear_cmd_r;
  logic sw_alm_reset_r;

  function automatic logic signed [31:0] preset_pos_sx(input logic signed [23:0] v);
    preset_pos_sx = 32'(v);
  endfunction : preset_pos_sx

  logic wr_en;
  logic setup;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= 1'b0;
      action_r <= ACT_NONE;
      out_sel_r <= `RST_OUTSEL;
      band_r <= `RST_BAND;
      enc_res_r <= `RST_ENC_RES;
      motor_res_r <= `RST_MOTOR_RES;
      preset_pos_r <= '0;
      enc_preset_r <= '0;
      wrap_en_r <= 1'b0;
      wrap_value_r <= `RST_WRAP_VALUE;
      gpo_r <= 6'h00;
      enc_preset_cmd_r <= 1'b0;
      cnt_clear_cmd_r <= 1'b0;
      sw_alm_reset_r <= 1'b0;
    end else begin
      enc_preset_cmd_r <= 1'b0;
      cnt_clear_cmd_r <= 1'b0;
      sw_alm_reset_r <= 1'b0;
      if (wr_en) begin
        unique case (paddr)
          `OFS_CTRL: begin
            enable_r <= pwdata[`CTRL_ENABLE_BIT];
            // The unused fourth code falls back to no action.
            if (pwdata[`CTRL_ACTION_LSB+:2] == 2'b11) begin
              action_r <= ACT_NONE;
            end else begin
              action_r <= action_t'(pwdata[`CTRL_ACTION_LSB+:2]);
            end
            out_sel_r <= pwdata[`CTRL_OUTSEL_LSB+:3];
            enc_preset_cmd_r <= pwdata[`CTRL_ENC_PRESET_BIT];
            cnt_clear_cmd_r <= pwdata[`CTRL_CNT_CLEAR_BIT];
            sw_alm_reset_r <= pwdata[`CTRL_ALM_RESET_BIT];
          end
          `OFS_BAND: band_r <= pwdata[11:0];
          `OFS_ENC_RES: enc_res_r <= pwdata[13:0];
          `OFS_MOTOR_RES: motor_res_r <= pwdata[17:0];
          `OFS_PRESET_POS: preset_pos_r <= pwdata[23:0];
          `OFS_ENC_PRESET: enc_preset_r <= pwdata[23:0];
          `OFS_WRAP_CTRL: wrap_en_r <= pwdata[0];
          `OFS_WRAP_VALUE: wrap_value_r <= pwdata;
          `OFS_GPO: gpo_r <= pwdata[5:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  logic [1:0] preset_sync_r;
  logic [1:0] almrst_sync_r;
  logic preset_prev_r;
  logic almrst_prev_r;
  logic preset_evt;
  logic almrst_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_sync_r <= 2'b00;
      almrst_sync_r <= 2'b00;
      preset_prev_r <= 1'b0;
      almrst_prev_r <= 1'b0;
    end else begin
      preset_sync_r <= {preset_sync_r[0], preset_pin};
      almrst_sync_r <= {almrst_sync_r[0], alarm_reset_input};
      preset_prev_r <= preset_sync_r[1];
      almrst_prev_r <= almrst_sync_r[1];
    end
  end

  assign preset_evt = preset_sync_r[1] && !preset_prev_r;
  assign almrst_evt = (almrst_sync_r[1] && !almrst_prev_r) || sw_alm_reset_r;

  // ----------------------------------------------------------------------------
  // Encoder counter
  // ----------------------------------------------------------------------------
  logic cnt_up;
  logic cnt_dn;
  logic signed [31:0] enc_cnt_r;

  quad_decoder u_quad (
    .pclk(pclk),
    .presetn(presetn),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .cnt_up(cnt_up),
    .cnt_dn(cnt_dn)
  );

  // The encoder resolution is deliberately absent here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_cnt_r <= '0;
    end else if (cnt_clear_cmd_r) begin
      enc_cnt_r <= '0;
    end else if (enc_preset_cmd_r) begin
      enc_cnt_r <= 32'(preset_pos_sx(enc_preset_r));
    end else if (cnt_up) begin
      enc_cnt_r <= enc_cnt_r + 32'sd1;
    end else if (cnt_dn) begin
      enc_cnt_r <= enc_cnt_r - 32'sd1;
    end
  end

  // ----------------------------------------------------------------------------
  // Feedback position in motor steps
  // ----------------------------------------------------------------------------
  // Each encoder count adds one motor resolution to a remainder, and one step
  // is released per clock while the remainder is at least one encoder revolution.
  // At very high step-to-count ratios this lags briefly, never drifts.
  logic signed [31:0] fb_pos_r;
  logic [31:0] fb_wrap_r;
  logic signed [33:0] fb_acc_r;
  logic signed [33:0] acc_den;
  logic fb_inc;
  logic fb_dec;

  assign acc_den = 34'(enc_res_r) * 34'sd4;
  assign fb_inc = fb_acc_r >= acc_den;
  assign fb_dec = fb_acc_r <= -acc_den;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_acc_r <= '0;
      fb_pos_r <= '0;
      fb_wrap_r <= '0;
    end else if (cnt_clear_cmd_r) begin
      fb_acc_r <= '0;
      fb_pos_r <= '0;
      fb_wrap_r <= '0;
    end else if (preset_evt) begin
      fb_acc_r <= '0;
      fb_pos_r <= preset_pos_sx(preset_pos_r);
      fb_wrap_r <= 32'(preset_pos_sx(preset_pos_r));
    end else begin
      fb_acc_r <= fb_acc_r
                  + (cnt_up ? 34'(motor_res_r) : 34'sd0)
                  - (cnt_dn ? 34'(motor_res_r) : 34'sd0)
                  - (fb_inc ? acc_den : 34'sd0)
                  + (fb_dec ? acc_den : 34'sd0);
      if (fb_inc) begin
        fb_pos_r <= fb_pos_r + 32'sd1;
        fb_wrap_r <= (fb_wrap_r + 32'd1 >= wrap_value_r) ? 32'd0 : fb_wrap_r + 32'd1;
      end else if (fb_dec) begin
        fb_pos_r <= fb_pos_r - 32'sd1;
        fb_wrap_r <= (fb_wrap_r == 32'd0) ? wrap_value_r - 32'd1 : fb_wrap_r - 32'd1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Command position
  // ----------------------------------------------------------------------------
  logic signed [31:0] cmd_pos_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pos_r <= '0;
    end else if (cnt_clear_cmd_r || home_done) begin
      cmd_pos_r <= '0;
    end else if (preset_evt) begin
      cmd_pos_r <= preset_pos_sx(preset_pos_r);
    end else if (enable_r && !motor_excited) begin
      cmd_pos_r <= fb_pos_r;
    end else if (step_pulse) begin
      cmd_pos_r <= step_dir ? cmd_pos_r + 32'sd1 : cmd_pos_r - 32'sd1;
    end
  end

  // ----------------------------------------------------------------------------
  // Deviation checking
  // ----------------------------------------------------------------------------
  logic over_band;
  logic [31:0] settle_cnt_r;
  logic armed;
  logic err_clear;
  logic pos_jump;
  logic [1:0] clr_blank_r;

  deviation_calc u_dev (
    .pclk(pclk),
    .presetn(presetn),
    .cmd_pos(cmd_pos_r),
    .enc_cnt(enc_cnt_r),
    .motor_res(motor_res_r),
    .enc_res(enc_res_r),
    .band(band_r),
    .over_band(over_band)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_r <= '0;
    end else if (!motor_excited) begin
      settle_cnt_r <= '0;
    end else if (settle_cnt_r != 32'(SETTLE_CYCLES)) begin
      settle_cnt_r <= settle_cnt_r + 32'd1;
    end
  end

  assign armed = enable_r && motor_excited && !mech_home_busy
                 && settle_cnt_r == 32'(SETTLE_CYCLES);
  assign err_clear = !motor_excited || mech_home_busy || cnt_clear_cmd_r;
  assign pos_jump = cnt_clear_cmd_r || enc_preset_cmd_r || preset_evt || home_done;

  // The comparison pipeline still holds the old positions for the cycle of a
  // position jump and the two after it, so detection is blanked there; else a
  // counter clear would be undone at once by a stale deviation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_blank_r <= 2'b00;
      deviation_error <= 1'b0;
    end else begin
      clr_blank_r <= {clr_blank_r[0], pos_jump};
      if (armed && over_band && !pos_jump && clr_blank_r == 2'b00) begin
        deviation_error <= 1'b1;
      end else if (err_clear) begin
        deviation_error <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Warning and alarm
  // ----------------------------------------------------------------------------
  alarm_state_t alm_state_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alm_state_r <= ALM_IDLE;
    end else begin
      unique case (alm_state_r)
        ALM_IDLE: begin
          if (deviation_error && action_r == ACT_ALARM) begin
            alm_state_r <= ALM_ACTIVE;
          end
        end
        ALM_ACTIVE: begin
          if (almrst_evt) begin
            alm_state_r <= ALM_RESET_SEEN;
          end
        end
        ALM_RESET_SEEN: begin
          if (err_clear) begin
            alm_state_r <= ALM_IDLE;
          end
        end
        default: alm_state_r <= ALM_IDLE;
      endcase
    end
  end

  assign deviation_alarm = alm_state_r != ALM_IDLE;
  assign deviation_warning = deviation_error && action_r == ACT_WARN;

  // ----------------------------------------------------------------------------
  // General outputs
  // ----------------------------------------------------------------------------
  logic [5:0] gen_out_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_out_r <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        gen_out_r[i] <= (out_sel_r == 3'(i)) ? deviation_error : gpo_r[i];
      end
    end
  end

  assign general_output_first = gen_out_r[0];
  assign general_output_second = gen_out_r[1];
  assign general_output_third = gen_out_r[2];
  assign general_output_fourth = gen_out_r[3];
  assign general_output_fifth = gen_out_r[4];
  assign general_output_last = gen_out_r[5];

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  // Read data is captured in the setup cycle so the access phase needs no wait.
  logic bad_addr_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      bad_addr_r <= 1'b0;
    end else if (setup) begin
      bad_addr_r <= 1'b0;
      prdata <= 32'h0000_0000;
      unique case (paddr)
        `OFS_CTRL: prdata <= {24'h00_0000, 1'b0, out_sel_r, 1'b0, action_r, enable_r};
        `OFS_BAND: prdata <= 32'(band_r);
        `OFS_ENC_RES: prdata <= 32'(enc_res_r);
        `OFS_MOTOR_RES: prdata <= 32'(motor_res_r);
        `OFS_PRESET_POS: prdata <= preset_pos_sx(preset_pos_r);
        `OFS_ENC_PRESET: prdata <= preset_pos_sx(enc_preset_r);
        `OFS_CMD_POS: prdata <= cmd_pos_r;
        `OFS_ENC_CNT: prdata <= enc_cnt_r;
        `OFS_FB_POS: prdata <= wrap_en_r ? fb_wrap_r : fb_pos_r;
        `OFS_WRAP_CTRL: prdata <= {31'h0000_0000, wrap_en_r};
        `OFS_WRAP_VALUE: prdata <= wrap_value_r;
        `OFS_STATUS: prdata <= {28'h000_0000, armed, deviation_alarm,
                                deviation_warning, deviation_error};
        `OFS_GPO: prdata <= 32'(gpo_r);
        default: bad_addr_r <= 1'b1;
      endcase
    end
  end

  assign pslverr = psel && penable && bad_addr_r;

endmodule : encoder_misstep_monitor

/* File: dv/quad_enc_model.sv */
// Quadrature encoder model driving channel A/B for the misstep monitor.
`timescale 1ns/1ps
module quad_enc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mv,
  input wire logic fwd,
  input wire logic dbl,
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph_r;
  // ----
  // Phase
  // ----
  // The order 00, 10, 11, 01 of {A, B} is the counting-up sense.
  // A double step flips both channels at once, which the decoder must ignore.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= 2'h0;
    end else if (dbl) begin
      ph_r <= ~ph_r;
    end else if (mv) begin
      ph_r <= fwd ? {~ph_r[0], ph_r[1]} : {ph_r[0], ~ph_r[1]};
    end
  end
  assign enc_a = ph_r[1];
  assign enc_b = ph_r[0];
endmodule : quad_enc_model

/* File: dv/misstep_chk.sv */
// Port checker of the misstep monitor.
`timescale 1ns/1ps
module misstep_chk #(
  parameter int unsigned SETTLE_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic motor_excited,
  input wire logic mech_home_busy,
  input wire logic deviation_error,
  input wire logic deviation_warning,
  input wire logic deviation_alarm
);
  int unsigned exc_cnt_r;
  // ----
  // Excitation time
  // ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_cnt_r <= 0;
    end else if (!motor_excited) begin
      exc_cnt_r <= 0;
    end else if (exc_cnt_r < SETTLE_CYCLES) begin
      exc_cnt_r <= exc_cnt_r + 1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_always_a: assert property (pready)
    else $error("pready low");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  slverr_data_a: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read data not zero");
  warn_cause_a: assert property (deviation_warning |-> deviation_error)
    else $error("warning without error");
  settle_gate_a: assert property ($rose(deviation_error) |-> exc_cnt_r >= SETTLE_CYCLES)
    else $error("error before settle time");
  idle_clear_a: assert property (!motor_excited [*2] |-> !deviation_error)
    else $error("error kept while not excited");
  home_clear_a: assert property (mech_home_busy [*2] |-> !deviation_error)
    else $error("error during mechanical home");
  alarm_cause_a: assert property ($rose(deviation_alarm) |-> $past(deviation_error))
    else $error("alarm without error");
  alarm_exit_a: assert property ($fell(deviation_alarm) |-> !deviation_error)
    else $error("alarm left with error standing");
  cover property ($rose(deviation_alarm));
  cover property ($rose(deviation_warning));
  cover property (pslverr);
endmodule : misstep_chk

bind encoder_misstep_monitor misstep_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .motor_excited(motor_excited),
  .mech_home_busy(mech_home_busy), .deviation_error(deviation_error),
  .deviation_warning(deviation_warning), .deviation_alarm(deviation_alarm));

/* File: dv/encoder_misstep_monitor_tb.sv */
// Self-checking bench of the misstep monitor.
`timescale 1ns/1ps
`include "misstep_regs.svh"
module encoder_misstep_monitor_tb;
  import misstep_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, step_pulse, step_dir, motor_excited;
  logic home_done, mech_home_busy, preset_pin, alarm_reset_input, mv, fwd, dbl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, enc_a, enc_b, dev_err, dev_warn, dev_alm, rerr;
  logic [5:0] gout;
  logic [31:0] lfsr_r = 32'h0000_36F6;
  int miscompares = 0, n_compared = 0, cyc = 0, m_cmd, m_enc, n;

  encoder_misstep_monitor #(.SETTLE_CYCLES(40)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .step_pulse(step_pulse),
    .step_dir(step_dir), .motor_excited(motor_excited), .home_done(home_done),
    .mech_home_busy(mech_home_busy), .enc_a(enc_a), .enc_b(enc_b), .preset_pin(preset_pin),
    .alarm_reset_input(alarm_reset_input), .deviation_error(dev_err),
    .deviation_warning(dev_warn), .deviation_alarm(dev_alm), .general_output_first(gout[0]),
    .general_output_second(gout[1]), .general_output_third(gout[2]),
    .general_output_fourth(gout[3]), .general_output_fifth(gout[4]),
    .general_output_last(gout[5]));
  quad_enc_model u_enc (.pclk(pclk), .presetn(presetn), .mv(mv), .fwd(fwd), .dbl(dbl),
    .enc_a(enc_a), .enc_b(enc_b));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic end_sim();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // One idle edge leads each transfer, so psel is never assigned twice in a step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdc
  task automatic steps(input int k, input logic up);
    repeat (k) begin
      @(posedge pclk);
      {step_pulse, step_dir} <= {1'b1, up};
      @(posedge pclk);
      step_pulse <= 0;
      m_cmd += up ? 1 : -1;
    end
  endtask : steps
  task automatic enc(input int k, input logic up, input logic both);
    repeat (k) begin
      @(posedge pclk);
      {mv, dbl, fwd} <= {!both, both, up};
      @(posedge pclk);
      {mv, dbl} <= 2'b00;
      repeat (6) @(posedge pclk);
      if (!both) m_enc += up ? 1 : -1;
    end
  endtask : enc

  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      end_sim();
    end
  end

  // ----
  // Sequence
  // ----
  initial begin
    {psel, penable, pwrite, step_pulse, step_dir, motor_excited, home_done} = '0;
    {mech_home_busy, preset_pin, alarm_reset_input, mv, fwd, dbl, paddr, pwdata} = '0;
    {presetn, m_cmd, m_enc} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rdc(`OFS_CTRL, 32'h0000_0070);
    rdc(`OFS_BAND, 32'h0000_0048);
    rdc(`OFS_ENC_RES, 32'h0000_01F4);
    rdc(`OFS_ENC_PRESET, 32'h0000_0000);
    rdc(12'hFFC, 32'h0000_0000);
    check(rerr, 1);
    lfsr_r = lfsr(lfsr_r);
    n = lfsr_r[3:0] + 4;
    enc(n, 1, 0);
    enc(3, 0, 0);
    enc(2, 0, 1);
    rdc(`OFS_ENC_CNT, m_enc);
    wr(`OFS_ENC_PRESET, 32'h00FF_FFFB);
    wr(`OFS_CTRL, 32'h0000_0170);
    m_enc = -5;
    rdc(`OFS_ENC_CNT, m_enc);
    wr(`OFS_PRESET_POS, 32'h00FF_FFFD);
    @(posedge pclk);
    preset_pin <= 1;
    repeat (6) @(posedge pclk);
    preset_pin <= 0;
    m_cmd = -3;
    rdc(`OFS_CMD_POS, m_cmd);
    rdc(`OFS_FB_POS, m_cmd);
    steps(n, 1);
    rdc(`OFS_CMD_POS, m_cmd);
    @(posedge pclk);
    home_done <= 1;
    @(posedge pclk);
    home_done <= 0;
    m_cmd = 0;
    rdc(`OFS_CMD_POS, m_cmd);
    for (int act = 0; act < 3; act++) begin
      wr(`OFS_CTRL, 32'h0000_0201 | (act << 1) | (act << 4));
      {m_cmd, m_enc} = '0;
      @(posedge pclk);
      motor_excited <= 1;
      // Ten steps of 0.72 degrees land exactly on the default band.
      steps(10, 1);
      // The band is reached here, yet excitation is still short of the settle time.
      repeat (8) @(posedge pclk);
      check(dev_err, 0);
      repeat (32) @(posedge pclk);
      check(dev_err, 1);
      check(dev_warn, act == 1);
      check(dev_alm, act == 2);
      check(gout, 6'h01 << act);
      if (act == 2) begin
        @(posedge pclk);
        alarm_reset_input <= 1;
        repeat (6) @(posedge pclk);
        alarm_reset_input <= 0;
        repeat (8) @(posedge pclk);
        check(dev_alm, 1);
      end
      @(posedge pclk);
      case (act)
        0: wr(`OFS_CTRL, 32'h0000_0201);
        1: mech_home_busy <= 1;
        default: motor_excited <= 0;
      endcase
      repeat (8) @(posedge pclk);
      check(dev_err, 0);
      check(dev_alm, 0);
      {mech_home_busy, motor_excited} <= 2'b00;
    end
    wr(`OFS_ENC_RES, 32'h0000_00FA);
    wr(`OFS_WRAP_VALUE, 32'h0000_0003);
    wr(`OFS_WRAP_CTRL, 32'h0000_0001);
    enc(8, 1, 0);
    rdc(`OFS_ENC_CNT, m_enc);
    rdc(`OFS_CMD_POS, m_enc / 2);
    rdc(`OFS_FB_POS, (m_enc / 2) % 3);
    end_sim();
  end
endmodule : encoder_misstep_monitor_tb
